// File: core/tbz_pkg.sv
// Purpose: shared constants for the timer / buzzer output block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package tbz_pkg;
    localparam int         AW          = 6;
    // register byte offsets
    localparam logic [5:0] OFF_T0CTL   = 6'h00;
    localparam logic [5:0] OFF_T0PRE   = 6'h04;
    localparam logic [5:0] OFF_T0CNT   = 6'h08;
    localparam logic [5:0] OFF_T1CTL   = 6'h0c;
    localparam logic [5:0] OFF_T1PRE   = 6'h10;
    localparam logic [5:0] OFF_T1CNT   = 6'h14;
    localparam logic [5:0] OFF_PFS     = 6'h18;
    localparam logic [5:0] OFF_SYS1    = 6'h1c;
    localparam logic [5:0] OFF_PDIR    = 6'h20;
    localparam logic [5:0] OFF_PDAT    = 6'h24;
    localparam logic [5:0] OFF_IRQ     = 6'h28;
    localparam logic [5:0] OFF_PDN     = 6'h2c;
    // timer control fields
    localparam int         F_MODE_HI   = 7;
    localparam int         F_MODE_LO   = 6;
    localparam int         F_RUN       = 4;
    localparam int         F_EDGE      = 3;
    localparam int         F_PSC_HI    = 2;
    localparam int         F_PSC_LO    = 0;
    // pin function select fields
    localparam int         F_PIN2_BZ   = 1;
    localparam int         F_PIN1_BZ   = 0;
    localparam int         PFS_W       = 2;
    // port a pin indices
    localparam int         PIN1        = 1;
    localparam int         PIN2        = 2;
    localparam int         PIN_TMR     = 0;
    // irq register fields: flags 1:0, enables 5:4
    localparam int         F_FLAG0     = 0;
    localparam int         F_EN0       = 4;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] RST_PDIR    = 8'hff;

    // operating mode encoding
    typedef enum logic [1:0]
    {
        MODE_NONE  = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PWM   = 2'h3
    } tbz_mode_e;

    // signals from register file into one timer
    typedef struct packed
    {
        logic [7:0] ctl;
        logic [7:0] pre;
        logic       pre_wr;
        logic       cnt_rd;
        logic       tin;
    } tbz_tcfg_s;
endpackage : tbz_pkg

// File: core/tbz_tmr_if.sv
// Purpose: bundle between register file and one timer
// Assumes: single pclk domain
// Notes:   status flows back as count, overflow and run clear
`timescale 1ns/100ps
interface tbz_tmr_if;
    tbz_pkg::tbz_tcfg_s cfg;
    logic [7:0]         cnt;
    logic               ovf;
    logic               run_clr;
    modport regs (output cfg, input cnt, input ovf, input run_clr);
    modport tmr  (input cfg, output cnt, output ovf, output run_clr);
endinterface : tbz_tmr_if

// File: core/tbz_timer.sv
// Purpose: one 8-bit timer/event counter with prescaler and preload
// Assumes: tin already synchronised to pclk
// Notes:   overflow is a one-cycle pulse
`timescale 1ns/100ps
module tbz_timer
(
    // system
    input  wire logic pclk,
    input  wire logic presetn,
    // register side
    tbz_tmr_if.tmr    t
);
    typedef struct packed
    {
        logic [7:0] cnt;
        logic [6:0] psc;
        logic       tin;
        logic       arm;
        logic       ovf;
        logic       rclr;
    } tbz_tst_s;

    tbz_tst_s s_q;
    tbz_tst_s s_d;
    logic [7:0] dv;
    logic       tick;
    logic [1:0] md;
    logic       act;
    logic       rise;
    logic       fall;

    // next state of counter, prescaler and pulse-width arm
    always_comb
    begin
        s_d      = s_q;
        md       = t.cfg.ctl[tbz_pkg::F_MODE_HI:tbz_pkg::F_MODE_LO];
        rise     = t.cfg.tin & ~s_q.tin;
        fall     = ~t.cfg.tin & s_q.tin;
        act      = t.cfg.ctl[tbz_pkg::F_EDGE] ? rise : fall;
        s_d.tin  = t.cfg.tin;
        s_d.ovf  = 1'b0;
        s_d.rclr = 1'b0;
        s_d.psc  = s_q.psc + 7'h01;
        // ratio 2^n: tick when the low n bits wrap (high-to-low of divided clock)
        dv   = 8'h01 << t.cfg.ctl[tbz_pkg::F_PSC_HI:tbz_pkg::F_PSC_LO];
        tick = ((s_q.psc & 7'(dv - 8'h01)) == 7'(dv - 8'h01));
        if (!t.cfg.ctl[tbz_pkg::F_RUN])
        begin
            s_d.arm = 1'b0;
        end
        else
        begin
            unique case (md)
                // event counting uses the opposite edge sense to the pulse-width start edge
                tbz_pkg::MODE_EVENT: tick = t.cfg.ctl[tbz_pkg::F_EDGE] ? fall : rise;
                tbz_pkg::MODE_TIMER: ;
                tbz_pkg::MODE_PWM:
                begin
                    // arm on the active edge, stop and clear run on the return edge
                    if (act)
                        s_d.arm = 1'b1;
                    if (s_q.arm && (t.cfg.ctl[tbz_pkg::F_EDGE] ? fall : rise))
                    begin
                        s_d.arm  = 1'b0;
                        s_d.rclr = 1'b1;
                    end
                    tick = tick & s_q.arm;
                end
                default: tick = 1'b0;
            endcase
            // bus access to counter or preload inhibits the count, may lose one
            if (tick && !t.cfg.pre_wr && !t.cfg.cnt_rd)
            begin
                if (s_q.cnt == 8'hff)
                begin
                    s_d.cnt = t.cfg.pre;
                    s_d.ovf = 1'b1;
                end
                else
                    s_d.cnt = s_q.cnt + 8'h01;
            end
        end
        if (!t.cfg.ctl[tbz_pkg::F_RUN] && t.cfg.pre_wr)
            s_d.cnt = t.cfg.pre;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign t.cnt     = s_q.cnt;
    assign t.ovf     = s_q.ovf;
    assign t.run_clr = s_q.rclr;
endmodule : tbz_timer

// File: core/tbz_top.sv
// Function
// - internal clock divided by prescaler ratio from three-bit field
// - buzzer toggles on selected timer overflow, frequency is overflow rate over two
// - second buzzer pin drives inverse of first when both paired and pin1 is an output; with pin1 an input pin2 drives the true wave
// - pin1 data bit gates buzzer; low forces buzzer pins low
// - pin2 data bit ignored while pin2 is inverted buzzer
// - only pin1 selected leaves pin2 as plain port pin
// - direction bit high makes buzzer pin an input
// - pin function follows the select/direction truth table
// - select register has two rw bits reset zero
// - select register bits 7 to 2 read zero
// - pull-high on timer pin stays while used as timer input
// - external input acts only at next timer clock
// - counter clock inhibited during counter read or preload write
// - overflow sets request flag; interrupt only when enabled
// - overflow with its flag clear wakes from power-down regardless of enable
// - control bit 4 starts and stops counter
// - mode field 00 none, 01 event, 10 timer, 11 pulse width
// - overflow reloads from preload and continues
// - timer mode counts on each fall of prescaled clock
//
// Purpose: two timers, buzzer pair and port a pin control behind apb
// Assumes: pclk 10 MHz, presetn asynchronous active low
// Notes:   port a is 8 pins; pin 0 carries the external timer input
`timescale 1ns/100ps
module tbz_top
#(
    parameter int PINS = 8
)
(
    // apb slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [5:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    // port a pins
    input  wire logic [PINS-1:0]  pa_in,
    output logic      [PINS-1:0]  pa_out,
    output logic      [PINS-1:0]  pa_oe,
    output logic      [PINS-1:0]  pa_pullup,
    // processor side
    output logic                  irq,
    output logic                  wake
);
    typedef struct packed
    {
        logic [7:0]      ctl0;
        logic [7:0]      ctl1;
        logic [7:0]      pre0;
        logic [7:0]      pre1;
        logic [1:0]      pfs;
        logic            buzzer_clock_source_select;
        logic [PINS-1:0] pdir;
        logic [PINS-1:0] pdat;
        logic [PINS-1:0] ppu;
        logic [1:0]      flag;
        logic [1:0]      ien;
        logic            pdn;
        logic            bz;
        logic [PINS-1:0] sy1;
        logic [PINS-1:0] sy2;
        logic            rdy;
        logic            err;
        logic [31:0]     rd;
        logic            pw0;
        logic            pw1;
        logic            cr0;
        logic            cr1;
        logic [PINS-1:0] out;
        logic [PINS-1:0] oe;
        logic            irq;
        logic            wake;
    } tbz_st_s;

    tbz_st_s s_q;
    tbz_st_s s_d;
    tbz_tmr_if ti0 ();
    tbz_tmr_if ti1 ();
    logic      acc;
    logic      wr;
    logic      hit;
    logic      bz_on;
    logic      p1bz;
    logic      p2bz;

    // true for a known register offset
    function automatic logic is_mapped(input logic [5:0] a);
        is_mapped = (a == tbz_pkg::OFF_T0CTL) || (a == tbz_pkg::OFF_T0PRE) || (a == tbz_pkg::OFF_T0CNT)
                 || (a == tbz_pkg::OFF_T1CTL) || (a == tbz_pkg::OFF_T1PRE) || (a == tbz_pkg::OFF_T1CNT)
                 || (a == tbz_pkg::OFF_PFS)   || (a == tbz_pkg::OFF_SYS1)  || (a == tbz_pkg::OFF_PDIR)
                 || (a == tbz_pkg::OFF_PDAT)  || (a == tbz_pkg::OFF_IRQ)   || (a == tbz_pkg::OFF_PDN);
    endfunction : is_mapped

    // timer control path: pre_wr/cnt_rd are the setup-phase access so the inhibit covers the transfer
    always_comb
    begin
        ti0.cfg.ctl    = s_q.ctl0;
        ti0.cfg.pre    = s_q.pre0;
        ti0.cfg.pre_wr = s_q.pw0;
        ti0.cfg.cnt_rd = s_q.cr0;
        ti0.cfg.tin    = s_q.sy2[tbz_pkg::PIN_TMR];
        ti1.cfg.ctl    = s_q.ctl1;
        ti1.cfg.pre    = s_q.pre1;
        ti1.cfg.pre_wr = s_q.pw1;
        ti1.cfg.cnt_rd = s_q.cr1;
        ti1.cfg.tin    = s_q.sy2[tbz_pkg::PIN_TMR];
    end

    tbz_timer u_t0
    (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (ti0.tmr)
    );

    tbz_timer u_t1
    (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (ti1.tmr)
    );

    // apb decode, registers, buzzer and pin muxing
    always_comb
    begin
        s_d     = s_q;
        acc     = psel & penable & ~s_q.rdy;
        wr      = acc & pwrite;
        hit     = is_mapped(paddr);
        s_d.rdy = acc;
        s_d.err = acc & ~hit;
        s_d.pw0 = psel & pwrite & (paddr == tbz_pkg::OFF_T0PRE);
        s_d.pw1 = psel & pwrite & (paddr == tbz_pkg::OFF_T1PRE);
        s_d.cr0 = psel & ~pwrite & (paddr == tbz_pkg::OFF_T0CNT);
        s_d.cr1 = psel & ~pwrite & (paddr == tbz_pkg::OFF_T1CNT);
        // two-flop synchroniser on every port pin
        s_d.sy1 = pa_in;
        s_d.sy2 = s_q.sy1;
        // hardware clears run bit at end of a pulse-width measurement
        if (ti0.run_clr)
            s_d.ctl0[tbz_pkg::F_RUN] = 1'b0;
        if (ti1.run_clr)
            s_d.ctl1[tbz_pkg::F_RUN] = 1'b0;
        if (wr)
        begin
            unique case (paddr)
                tbz_pkg::OFF_T0CTL: s_d.ctl0 = pwdata[7:0];
                tbz_pkg::OFF_T1CTL: s_d.ctl1 = pwdata[7:0];
                tbz_pkg::OFF_T0PRE: s_d.pre0 = pwdata[7:0];
                tbz_pkg::OFF_T1PRE: s_d.pre1 = pwdata[7:0];
                tbz_pkg::OFF_PFS:   s_d.pfs  = pwdata[tbz_pkg::PFS_W-1:0];
                tbz_pkg::OFF_SYS1:  s_d.buzzer_clock_source_select = pwdata[0];
                tbz_pkg::OFF_PDIR:  s_d.pdir = pwdata[PINS-1:0];
                tbz_pkg::OFF_PDAT:  s_d.pdat = pwdata[PINS-1:0];
                tbz_pkg::OFF_IRQ:
                begin
                    s_d.flag = pwdata[tbz_pkg::F_FLAG0+1:tbz_pkg::F_FLAG0];
                    s_d.ien  = pwdata[tbz_pkg::F_EN0+1:tbz_pkg::F_EN0];
                end
                tbz_pkg::OFF_PDN:   s_d.ppu  = pwdata[PINS-1:0];
                default: ;
            endcase
        end
        // power-down entry is bit 8 of the pull-up register word
        if (wr && paddr == tbz_pkg::OFF_PDN)
            s_d.pdn = pwdata[PINS];
        // overflow sets flag after any software write, so set wins
        if (ti0.ovf)
            s_d.flag[0] = 1'b1;
        if (ti1.ovf)
            s_d.flag[1] = 1'b1;
        // overflow whose flag is still clear leaves power-down whatever the enables
        if ((ti0.ovf && !s_q.flag[0]) || (ti1.ovf && !s_q.flag[1]))
        begin
            s_d.wake = 1'b1;
            s_d.pdn  = 1'b0;
        end
        else
            s_d.wake = 1'b0;
        s_d.irq = |(s_d.flag & s_q.ien);
        // toggle on selected overflow gives overflow rate over two
        if (s_q.buzzer_clock_source_select ? ti1.ovf : ti0.ovf)
            s_d.bz = ~s_q.bz;
        // read mux; unmapped returns zero with error
        s_d.rd = 32'h0000_0000;
        if (acc && !pwrite)
        begin
            unique case (paddr)
                tbz_pkg::OFF_T0CTL: s_d.rd[7:0] = s_q.ctl0;
                tbz_pkg::OFF_T1CTL: s_d.rd[7:0] = s_q.ctl1;
                tbz_pkg::OFF_T0PRE: s_d.rd[7:0] = s_q.pre0;
                tbz_pkg::OFF_T1PRE: s_d.rd[7:0] = s_q.pre1;
                tbz_pkg::OFF_T0CNT: s_d.rd[7:0] = ti0.cnt;
                tbz_pkg::OFF_T1CNT: s_d.rd[7:0] = ti1.cnt;
                tbz_pkg::OFF_PFS:   s_d.rd[tbz_pkg::PFS_W-1:0] = s_q.pfs;
                tbz_pkg::OFF_SYS1:  s_d.rd[0] = s_q.buzzer_clock_source_select;
                tbz_pkg::OFF_PDIR:  s_d.rd[PINS-1:0] = s_q.pdir;
                tbz_pkg::OFF_PDAT:  s_d.rd[PINS-1:0] = s_q.sy2;
                tbz_pkg::OFF_IRQ:
                begin
                    s_d.rd[tbz_pkg::F_FLAG0+1:tbz_pkg::F_FLAG0] = s_q.flag;
                    s_d.rd[tbz_pkg::F_EN0+1:tbz_pkg::F_EN0]     = s_q.ien;
                end
                tbz_pkg::OFF_PDN:   s_d.rd[PINS:0] = {s_q.pdn, s_q.ppu};
                default: ;
            endcase
        end
        // plain port behaviour for every pin, direction 1 = input
        s_d.out = s_q.pdat;
        s_d.oe  = ~s_q.pdir;
        // buzzer overrides; pin1 data bit is the on/off gate
        bz_on = s_q.pdat[tbz_pkg::PIN1];
        p1bz  = s_q.pfs[tbz_pkg::F_PIN1_BZ] & ~s_q.pdir[tbz_pkg::PIN1];
        p2bz  = s_q.pfs[tbz_pkg::F_PIN2_BZ] & ~s_q.pdir[tbz_pkg::PIN2];
        if (s_q.pfs[tbz_pkg::F_PIN1_BZ])
            s_d.out[tbz_pkg::PIN1] = p1bz & bz_on & s_q.bz;
        if (s_q.pfs[tbz_pkg::F_PIN2_BZ])
        begin
            // pin2 data bit unused; pin2 shows true wave if pin1 is input
            if (p1bz)
                s_d.out[tbz_pkg::PIN2] = p2bz & bz_on & ~s_q.bz;
            else
                s_d.out[tbz_pkg::PIN2] = p2bz & bz_on & s_q.bz;
        end
        s_d.out[tbz_pkg::PIN2] = s_d.out[tbz_pkg::PIN2] & (p2bz | ~s_q.pfs[tbz_pkg::F_PIN2_BZ]);
    end

    // state register; port direction resets to all inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q      <= '0;
            s_q.pdir <= {PINS{1'b1}};
            s_q.bz   <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign pready    = s_q.rdy;
    assign pslverr   = s_q.err;
    assign prdata    = s_q.rd;
    assign pa_out    = s_q.out;
    assign pa_oe     = s_q.oe;
    assign pa_pullup = s_q.ppu;
    assign irq       = s_q.irq;
    assign wake      = s_q.wake;
endmodule : tbz_top

// File: verif/tbz_top_asserts.sv
// Purpose: port checks for the timer / buzzer block
// Assumes: a register write lands at the same edge that raises pready; pin outputs are registered
// Notes:   pin registers are shadowed from accepted apb writes
`timescale 1ns/100ps
module tbz_top_asserts
#(
    parameter int PINS = 8
)
(
    // apb slave
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [5:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic [31:0]     prdata,
    // pins and processor side
    input wire logic [PINS-1:0] pa_in,
    input wire logic [PINS-1:0] pa_out,
    input wire logic [PINS-1:0] pa_oe,
    input wire logic [PINS-1:0] pa_pullup,
    input wire logic            irq,
    input wire logic            wake
);
    logic [1:0] pfs_q;
    logic [2:1] dir_q;
    logic [2:1] dat_q;
    logic [1:0] en_q;
    // shadows move at the edge the block stores a write, so they line up with its registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pfs_q <= 2'h0;
            dir_q <= 2'h3;
            dat_q <= 2'h0;
            en_q  <= 2'h0;
        end
        else if (psel && penable && !pready && pwrite)
        begin
            if (paddr == tbz_pkg::OFF_PFS) pfs_q <= pwdata[1:0];
            if (paddr == tbz_pkg::OFF_PDIR) dir_q <= pwdata[2:1];
            if (paddr == tbz_pkg::OFF_PDAT) dat_q <= pwdata[2:1];
            if (paddr == tbz_pkg::OFF_IRQ) en_q <= pwdata[5:4];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // apb answer: exactly one wait state, one-cycle pready
    a_ready_after_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    a_pfs_readback: assert property (pready && !pwrite && paddr == tbz_pkg::OFF_PFS |->
        prdata == {30'h0, pfs_q}) else $error("select register read wrong");
    // pin behaviour one cycle after the registers settle
    a_oe_follows_dir: assert property (pa_oe[2:1] == ~$past(dir_q))
        else $error("buzzer pin enable ignores direction");
    a_pin1_gated: assert property ($past(!dir_q[1] && !dat_q[1]) |-> !pa_out[1])
        else $error("pin1 driven high while gated");
    a_pair_inverse: assert property ($past(pfs_q == 2'h3 && dir_q == 2'h0 && dat_q[1]) |->
        pa_out[2] != pa_out[1]) else $error("pin pair not complementary");
    a_pin2_gated: assert property ($past(pfs_q[1] && !dir_q[2] && !dat_q[1]) |-> !pa_out[2])
        else $error("pin2 buzzer not gated by pin1 data");
    a_pin2_plain_io: assert property ($past(!pfs_q[1] && !dir_q[2]) |-> pa_out[2] == $past(dat_q[2]))
        else $error("pin2 not plain port pin");
    a_irq_needs_en: assert property (irq |-> $past(en_q) != 2'h0)
        else $error("interrupt without enable");
    a_wake_one_cycle: assert property (wake |=> !wake)
        else $error("wake longer than a pulse");
    c_refused: cover property (pready && pslverr);
    c_pair_wave: cover property ($past(pfs_q == 2'h3 && dir_q == 2'h0 && dat_q[1]) && $changed(pa_out[1]));
    c_wake: cover property (wake);
endmodule : tbz_top_asserts
bind tbz_top tbz_top_asserts #(.PINS(PINS)) tbz_top_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .irq(irq), .wake(wake));

// File: verif/tbz_pin_model.sv
// Purpose: far side: buzzer load on pins 1/2, event source on pin 0
// Assumes: an undriven pin without pull-up floats to a changing level
// Notes:   event edges fall off the clock grid on purpose
`timescale 1ns/100ps
module tbz_pin_model
(
    // pin side of the block
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pa_pullup,
    output logic      [7:0] pa_in
);
    logic       ev_lvl = 1'b1;
    logic [7:0] flt    = 8'h5a;
    // floating pins wander so a stale level never passes for a real one
    always #370 flt = ~flt;
    // wire level: device drive, else source on pin 0, else pull-up or float
    always_comb
    begin
        pa_in = (pa_oe & pa_out) | (~pa_oe & (pa_pullup | flt));
        if (!pa_oe[0]) pa_in[0] = ev_lvl;
    end
    // one event: low then back high, unrelated to pclk
    task automatic pulse(input int n);
        repeat (n)
        begin
            #1730 ev_lvl = 1'b0;
            #1730 ev_lvl = 1'b1;
        end
    endtask : pulse
endmodule : tbz_pin_model

// File: verif/tbz_tb_top.sv
// Purpose: self-checking bench for the timer / buzzer block
// Assumes: pins resolved by the far-side model
// Notes:   reads queue their expected word; a monitor compares at pready
`timescale 1ns/100ps
module tbz_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [5:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  pa_in;
    logic [7:0]  pa_out;
    logic [7:0]  pa_oe;
    logic [7:0]  pa_pullup;
    logic        irq;
    logic        wake;
    logic [32:0] exp_q[$];
    logic [7:0]  rnd = 8'h5d;
    int          err_count = 0;
    int          tests_run = 0;
    int          wakes = 0;
    int          cyc = 0;
    tbz_top #(.PINS(8)) tbz_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .irq(irq), .wake(wake));
    tbz_pin_model tbz_pin_model_i (.pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .pa_in(pa_in));
    // 10 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back({1'b0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    // cycles until pin 1 changes, capped so a dead buzzer cannot hang
    task automatic gap(output int c);
        logic p;
        c = 0;
        p = pa_out[1];
        do
        begin
            @(posedge pclk);
            c++;
        end
        while (pa_out[1] === p && c < 1000);
    endtask : gap
    // read monitor, cycle limit and wake counter
    always @(posedge pclk)
    begin
        cyc++;
        if (wake === 1'b1) wakes++;
        if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
        if (cyc == 60000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        int c;
        logic [1:0] dr;
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(tbz_pkg::OFF_PFS, 32'h0);
        rd(tbz_pkg::OFF_PDIR, {24'h0, tbz_pkg::RST_PDIR});
        // unmapped offset above the map, direction from the generator
        rnd = lfsr(rnd);
        if (!rnd[0]) exp_q.push_back(33'h1_0000_0000);
        apb(rnd[0], tbz_pkg::OFF_PDN + 6'h04 + (6'(rnd) & 6'h0c), {4{rnd}});
        rnd = lfsr(rnd);
        wr(tbz_pkg::OFF_PFS, {4{rnd}});
        rd(tbz_pkg::OFF_PFS, {30'h0, rnd[1:0]});
        // pin 1 buzzer from timer 0, every prescale ratio
        wr(tbz_pkg::OFF_PFS, 32'h1);
        wr(tbz_pkg::OFF_PDIR, 32'hfd);
        wr(tbz_pkg::OFF_PDAT, 32'h2);
        wr(tbz_pkg::OFF_T0PRE, 32'hfc);
        for (int p = 0; p < 8; p++)
        begin
            wr(tbz_pkg::OFF_T0CTL, 32'h90 | p);
            repeat (3) gap(c);
            chk(33'(c), 33'(4 << p));
        end
        wr(tbz_pkg::OFF_T0CTL, 32'h80);
        gap(c);
        gap(c);
        chk(33'(c), 33'd1000);
        wr(tbz_pkg::OFF_T1PRE, 32'hf0);
        wr(tbz_pkg::OFF_T1CTL, 32'h91);
        wr(tbz_pkg::OFF_SYS1, 32'h1);
        repeat (3) gap(c);
        chk(33'(c), 33'd32);
        // every select, direction and data combination with the wave running
        for (int i = 0; i < 64; i++)
        begin
            rnd = lfsr(rnd);
            dr = ~i[3:2];
            wr(tbz_pkg::OFF_PFS, 32'(i >> 4));
            wr(tbz_pkg::OFF_PDIR, {24'h0, 5'h1f, i[3:2], 1'b1});
            wr(tbz_pkg::OFF_PDAT, {24'h0, rnd[7:3], i[1:0], rnd[0]});
            repeat (3) @(posedge pclk);
            chk(pa_oe[2:1], dr);
            if (!i[2] && i[4] && i[0])
            begin
                // gated-on buzzer: the second gap is one full half period of timer 1
                gap(c);
                gap(c);
                chk(33'(c), 33'd32);
            end
            else if (!i[2]) chk(pa_out[1], i[0]);
            if (!i[3] && !(i[5] && i[0])) chk(pa_out[2], i[1] && !i[5]);
        end
        // event counting on pin 0 from the far side
        wr(tbz_pkg::OFF_T1CTL, 32'h0);
        wr(tbz_pkg::OFF_T0CTL, 32'h0);
        wr(tbz_pkg::OFF_PDIR, 32'hff);
        wr(tbz_pkg::OFF_PDN, 32'h1);
        wr(tbz_pkg::OFF_T0PRE, 32'hfc);
        wr(tbz_pkg::OFF_IRQ, 32'h0);
        wakes = 0;
        wr(tbz_pkg::OFF_T0CTL, 32'h50);
        chk(pa_pullup[0], 1'b1);
        tbz_pin_model_i.pulse(3);
        repeat (8) @(posedge pclk);
        rd(tbz_pkg::OFF_T0CNT, 32'hff);
        tbz_pin_model_i.pulse(1);
        repeat (8) @(posedge pclk);
        rd(tbz_pkg::OFF_T0CNT, 32'hfc);
        rd(tbz_pkg::OFF_IRQ, 32'h1);
        chk(irq, 1'b0);
        chk(33'(wakes), 33'd1);
        wr(tbz_pkg::OFF_IRQ, 32'h11);
        repeat (3) @(posedge pclk);
        chk(irq, 1'b1);
        wr(tbz_pkg::OFF_IRQ, 32'h1);
        tbz_pin_model_i.pulse(4);
        repeat (8) @(posedge pclk);
        chk(33'(wakes), 33'd1);
        wr(tbz_pkg::OFF_T0CTL, 32'h10);
        tbz_pin_model_i.pulse(2);
        rd(tbz_pkg::OFF_T0CNT, 32'hfc);
        wr(tbz_pkg::OFF_T0CTL, 32'hd0);
        tbz_pin_model_i.pulse(1);
        repeat (8) @(posedge pclk);
        rd(tbz_pkg::OFF_T0CTL, 32'hc0);
        stop_test();
    end
endmodule : tbz_tb_top
